// file: dv/fesp_flash_model.sv
`timescale 1ns/1ps
// behavioural flash; bench reads its counters
module fesp_flash_model (
    input  wire logic [fesp_pkg::ADDR_W-1:0] flash_addr,
    input  wire logic [7:0]                  flash_dq_out,
    input  wire logic                        flash_dq_oe_n,
    input  wire logic                        flash_ce_n,
    input  wire logic                        flash_we_n,
    input  wire logic                        flash_oe_n,
    input  wire logic                        flash_reset_vid,
    output logic      [7:0]                  flash_dq_in
);
    int                          seq = 0, vfy = 0, erase_left = 0, erase_polls = 4;
    int                          prot_need = 1, unprot_need = 1, prot_pulses = 0, unprot_pulses = 0;
    int                          pbase = 0, ubase = 0;
    logic [7:0]                  rd = 8'h5a;
    logic [fesp_pkg::ADDR_W-1:0] rd_addr = '0;
    logic [7:0]                  ud [6] = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55, 8'h10};
    // read mode until a full unlock sequence lands
    always @(posedge flash_we_n) begin
        if (!flash_ce_n) begin
            if (flash_reset_vid && flash_dq_out == fesp_pkg::CMD_PROT_PLS) begin
                prot_pulses   += int'(!flash_addr[6]);
                unprot_pulses += int'(flash_addr[6]);
            end else if (flash_reset_vid && flash_dq_out == fesp_pkg::CMD_PROT_VFY) begin
                vfy = flash_addr[6] ? 2 : 1;
            end else if (seq == 5 && flash_dq_out == ud[5] && flash_addr == fesp_pkg::UNLOCK_ADDR1) begin
                erase_left = erase_polls;
                seq = 0;
            end else begin
                seq = (flash_dq_out == ud[seq] && flash_addr == ((seq % 3 == 1) ? fesp_pkg::UNLOCK_ADDR2
                    : fesp_pkg::UNLOCK_ADDR1)) ? seq + 1 : 0;
            end
        end
    end
    always @(negedge flash_oe_n) begin
        rd_addr = flash_addr;
        if (vfy == 1)
            rd = (prot_pulses - pbase >= prot_need) ? 8'h01 : 8'h00;
        else if (vfy == 2)
            rd = (unprot_pulses - ubase >= unprot_need) ? 8'h00 : 8'h01;
        else if (erase_left > 0)
            rd = 8'h4c;
        else
            rd = 8'hff;
        if (vfy == 1 && rd == 8'h01)
            pbase = prot_pulses;
        if (vfy == 2 && rd == 8'h00)
            ubase = unprot_pulses;
        erase_left -= int'(erase_left > 0 && vfy == 0);
        vfy = 0;
    end
    // released bus shows the inverse: a late sample fails
    assign flash_dq_in = !flash_dq_oe_n ? flash_dq_out : ((!flash_ce_n && !flash_oe_n) ? rd : ~rd);
endmodule

// file: dv/fesp_sequencer_sva.sv
`timescale 1ns/1ps
module fesp_sequencer_sva #(
    parameter int unsigned PROT_WAIT_CYC   = 20,
    parameter int unsigned UNPROT_WAIT_CYC = 40
) (
    input logic                        core_clk,
    input logic                        rstn,
    input logic                        req_valid,
    input logic                        req_ready,
    input logic                        op_done,
    input logic                        op_failed,
    input logic [fesp_pkg::ADDR_W-1:0] flash_addr,
    input logic [fesp_pkg::DATA_W-1:0] flash_dq_out,
    input logic                        flash_dq_oe_n,
    input logic                        flash_ce_n,
    input logic                        flash_we_n,
    input logic                        flash_oe_n,
    input logic                        flash_reset_vid
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    int unsigned gap_q;
    logic        pend_q;
    logic        unp_q;
    // cycles since the last high-voltage pulse
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            gap_q  <= 0;
            pend_q <= 1'b0;
            unp_q  <= 1'b0;
        end else if ($rose(flash_we_n) && flash_reset_vid && flash_dq_out == fesp_pkg::CMD_PROT_PLS) begin
            gap_q  <= 0;
            pend_q <= 1'b1;
            unp_q  <= flash_addr[fesp_pkg::PROT_SEL_BIT];
        end else begin
            gap_q  <= gap_q + 1;
            pend_q <= pend_q && !$fell(flash_we_n);
        end
    end
    a_ready_busy: assert property (req_valid && req_ready |=> !req_ready)
        else $error("ready high");
    a_failed_clear: assert property (req_valid && req_ready |=> !op_failed)
        else $error("failed kept");
    a_done_pulse: assert property (op_done |=> !op_done)
        else $error("done long");
    a_write_strobe: assert property (!flash_we_n |-> !flash_ce_n && !flash_dq_oe_n && flash_oe_n)
        else $error("stray write");
    a_read_float: assert property (!flash_oe_n |-> !flash_ce_n && flash_dq_oe_n && flash_we_n)
        else $error("read driven");
    a_we_width: assert property ($fell(flash_we_n) |-> !flash_we_n [*3] ##1 flash_we_n)
        else $error("pulse width");
    a_vid_removed: assert property (op_done |-> !flash_reset_vid)
        else $error("vid at done");
    a_pulse_addr: assert property ($fell(flash_we_n) && flash_reset_vid
        && flash_dq_out == fesp_pkg::CMD_PROT_PLS
        |-> flash_addr[fesp_pkg::PROT_MODE_BIT] && !flash_addr[fesp_pkg::PROT_LOW_BIT])
        else $error("pulse addr");
    a_pulse_wait: assert property ($fell(flash_we_n) && pend_q
        |-> gap_q >= (unp_q ? UNPROT_WAIT_CYC : PROT_WAIT_CYC))
        else $error("early verify");
    a_idle_quiet: assert property (req_ready |-> flash_ce_n && flash_we_n && flash_oe_n)
        else $error("idle bus");
    c_fail: cover property (op_done && op_failed);
    c_pass: cover property (op_done && !op_failed);
    c_vid: cover property ($rose(flash_reset_vid));
endmodule

// file: dv/flash_erase_protect_sequencer_test.sv
`timescale 1ns/1ps
module flash_erase_protect_sequencer_test;
    logic                        core_clk = 1'b0;
    logic                        rstn = 1'b0;
    logic                        req_valid = 1'b0;
    fesp_pkg::fesp_op_type       req_op = fesp_pkg::FESP_OP_ERASE;
    logic [fesp_pkg::ADDR_W-1:0] sector_base [fesp_pkg::NUM_SECTORS];
    logic                        req_ready, op_done, op_failed, flash_dq_oe_n;
    logic                        flash_ce_n, flash_we_n, flash_oe_n, flash_reset_vid;
    logic [fesp_pkg::ADDR_W-1:0] flash_addr;
    logic [7:0]                  flash_dq_in, flash_dq_out;
    logic [27:0]                 wlog [$];
    int                          n_mismatch = 0;
    int                          n_checks = 0;

    always #25 core_clk = ~core_clk;
    always @(posedge flash_we_n) if (flash_ce_n === 1'b0) wlog.push_back({flash_reset_vid, flash_addr, flash_dq_out});

    fesp_sequencer #(.PROT_WAIT_CYC(20), .UNPROT_WAIT_CYC(40)) fesp_sequencer_inst (.*);
    fesp_flash_model fesp_flash_model_inst (.*);

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("MISMATCH %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // a poke while busy must be ignored
    task automatic run_op(input fesp_pkg::fesp_op_type op, input logic poke);
        wlog.delete();
        @(posedge core_clk);
        req_op    <= op;
        req_valid <= 1'b1;
        @(posedge core_clk);
        req_valid <= 1'b0;
        req_op    <= fesp_pkg::FESP_OP_PROTECT;
        repeat (4) @(posedge core_clk);
        req_valid <= poke;
        repeat (3) @(posedge core_clk);
        req_valid <= 1'b0;
        for (int i = 0; i < 20000; i++) begin
            @(posedge core_clk);
            #1;
            if (op_done === 1'b1)
                break;
        end
        check(op_done, 1'h1);
    endtask

    task automatic t_erase();
        fesp_flash_model_inst.erase_polls = 6;
        run_op(fesp_pkg::FESP_OP_ERASE, 1'b1);
        check(wlog.size(), 6);
        for (int i = 0; i < 6; i++)
            check(wlog[i], {1'b0, ((i % 3 == 1) ? fesp_pkg::UNLOCK_ADDR2 : fesp_pkg::UNLOCK_ADDR1),
                fesp_flash_model_inst.ud[i]});
        check(fesp_flash_model_inst.erase_left, 0);
        check(fesp_flash_model_inst.rd_addr, fesp_pkg::UNLOCK_ADDR1);
        check(op_failed, 1'h0);
        repeat (10) @(posedge core_clk);
        check({req_ready, flash_ce_n}, 2'h3);
    endtask

    task automatic t_prot(input int need, input logic fexp, input int np);
        int                          p0;
        logic [fesp_pkg::ADDR_W-1:0] pa;
        p0 = fesp_flash_model_inst.prot_pulses;
        fesp_flash_model_inst.prot_need = need;
        pa = {sector_base[0][18:7], 1'b0, sector_base[0][5:2], 2'h2};
        run_op(fesp_pkg::FESP_OP_PROTECT, 1'b0);
        check(op_failed, fexp);
        check(fesp_flash_model_inst.prot_pulses - p0, np);
        check(wlog[0], {1'b1, pa, fesp_pkg::CMD_PROT_PLS});
        check(wlog[1], {1'b1, pa, fesp_pkg::CMD_PROT_VFY});
        check(wlog[$], {1'b0, fesp_pkg::UNLOCK_ADDR1, fesp_pkg::CMD_RESET});
    endtask

    task automatic t_unprot();
        int                          p0, u0;
        logic [fesp_pkg::ADDR_W-1:0] ua;
        p0 = fesp_flash_model_inst.prot_pulses;
        u0 = fesp_flash_model_inst.unprot_pulses;
        fesp_flash_model_inst.prot_need = 1;
        fesp_flash_model_inst.unprot_need = 3;
        ua = {sector_base[0][18:7], 1'b1, sector_base[0][5:2], 2'h2};
        run_op(fesp_pkg::FESP_OP_UNPROT, 1'b0);
        check(op_failed, 1'h0);
        check(fesp_flash_model_inst.prot_pulses - p0, fesp_pkg::NUM_SECTORS);
        check(fesp_flash_model_inst.unprot_pulses - u0, 3 * fesp_pkg::NUM_SECTORS);
        check(wlog[2 * fesp_pkg::NUM_SECTORS], {1'b1, ua, fesp_pkg::CMD_PROT_PLS});
        check(wlog[2 * fesp_pkg::NUM_SECTORS + 1], {1'b1, ua, fesp_pkg::CMD_PROT_VFY});
        check(wlog[$], {1'b0, fesp_pkg::UNLOCK_ADDR1, fesp_pkg::CMD_RESET});
    endtask

    initial begin
        // bits 6, 1, 0 set: sequencer must overwrite them
        for (int i = 0; i < fesp_pkg::NUM_SECTORS; i++)
            sector_base[i] <= 19'(i * 32'h8000 + 32'h43);
        repeat (2) @(posedge core_clk);
        check({req_ready, flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe_n, flash_reset_vid}, 6'h3e);
        @(posedge core_clk);
        rstn <= 1'b1;
        t_erase();
        t_prot(2, 1'b0, 2 * fesp_pkg::NUM_SECTORS);
        t_prot(26, 1'b1, 25);
        t_unprot();
        tally_and_finish();
    end

    initial begin
        repeat (40000) @(posedge core_clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule

bind fesp_sequencer fesp_sequencer_sva #(.PROT_WAIT_CYC(PROT_WAIT_CYC), .UNPROT_WAIT_CYC(UNPROT_WAIT_CYC))
    fesp_sequencer_sva_inst (.*);

// file: hdl/fesp_bus_cycle.sv
`timescale 1ns/1ps
// one asynchronous flash bus cycle
module fesp_bus_cycle (
    input  wire logic                          core_clk,
    input  wire logic                          rstn,
    fesp_cyc_if.eng                            cyc,
    input  wire logic [fesp_pkg::DATA_W-1:0]   dq_in,
    output logic      [fesp_pkg::ADDR_W-1:0]   addr_o,
    output logic      [fesp_pkg::DATA_W-1:0]   dq_out,
    output logic                               dq_oe_n,
    output logic                               ce_n,
    output logic                               we_n,
    output logic                               oe_n
);
    typedef enum logic [2:0] {CY_IDLE, CY_SETUP, CY_PULSE, CY_HOLD, CY_READ, CY_SAMPLE} fesp_cy_state_type;
    typedef struct packed {
        fesp_cy_state_type              st;
        logic [3:0]                     cnt;
        logic [fesp_pkg::ADDR_W-1:0]    addr;
        logic [fesp_pkg::DATA_W-1:0]    wdata;
        logic [fesp_pkg::DATA_W-1:0]    rdata;
        logic [fesp_pkg::DATA_W-1:0]    sync1;
        logic [fesp_pkg::DATA_W-1:0]    sync2;
        logic                           done;
        logic                           dq_oe_n;
        logic                           ce_n;
        logic                           we_n;
        logic                           oe_n;
    } fesp_cy_reg_type;
    fesp_cy_reg_type s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        // data pins pass two flops before use; settle covered by access count
        s_d.sync1 = dq_in;
        s_d.sync2 = s_q.sync1;
        if (s_q.cnt != 4'h0) begin
            s_d.cnt = s_q.cnt - 4'h1;
        end
        unique case (s_q.st)
            CY_IDLE: begin
                if (cyc.start) begin
                    s_d.addr  = cyc.addr;
                    s_d.wdata = cyc.wdata;
                    s_d.ce_n  = 1'b0;
                    if (cyc.write) begin
                        s_d.dq_oe_n = 1'b0;
                        s_d.cnt     = fesp_pkg::WR_SETUP_CYC;
                        s_d.st      = CY_SETUP;
                    end else begin
                        s_d.oe_n = 1'b0;
                        s_d.cnt  = fesp_pkg::RD_ACCESS_CYC;
                        s_d.st   = CY_READ;
                    end
                end
            end
            CY_SETUP: if (s_q.cnt == 4'h0) begin
                s_d.we_n = 1'b0;
                s_d.cnt  = fesp_pkg::WR_PULSE_CYC;
                s_d.st   = CY_PULSE;
            end
            CY_PULSE: if (s_q.cnt == 4'h0) begin
                s_d.we_n = 1'b1;
                s_d.cnt  = fesp_pkg::WR_HOLD_CYC;
                s_d.st   = CY_HOLD;
            end
            CY_HOLD: if (s_q.cnt == 4'h0) begin
                s_d.dq_oe_n = 1'b1;
                s_d.ce_n    = 1'b1;
                s_d.done    = 1'b1;
                s_d.st      = CY_IDLE;
            end
            CY_READ: if (s_q.cnt == 4'h0) begin
                s_d.st = CY_SAMPLE;
            end
            CY_SAMPLE: begin
                s_d.rdata = s_q.sync2;
                s_d.oe_n  = 1'b1;
                s_d.ce_n  = 1'b1;
                s_d.done  = 1'b1;
                s_d.st    = CY_IDLE;
            end
            default: s_d.st = CY_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{st: CY_IDLE, cnt: '0, addr: '0, wdata: '0, rdata: '0, sync1: '0, sync2: '0,
                     done: 1'b0, dq_oe_n: 1'b1, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign cyc.done  = s_q.done;
    assign cyc.rdata = s_q.rdata;
    assign addr_o    = s_q.addr;
    assign dq_out    = s_q.wdata;
    assign dq_oe_n   = s_q.dq_oe_n;
    assign ce_n      = s_q.ce_n;
    assign we_n      = s_q.we_n;
    assign oe_n      = s_q.oe_n;
endmodule

// file: hdl/fesp_cyc_if.sv
`timescale 1ns/1ps
interface fesp_cyc_if;
    logic                           start;
    logic                           write;
    logic [fesp_pkg::ADDR_W-1:0]    addr;
    logic [fesp_pkg::DATA_W-1:0]    wdata;
    logic                           done;
    logic [fesp_pkg::DATA_W-1:0]    rdata;
    modport seq (output start, output write, output addr, output wdata, input done, input rdata);
    modport eng (input start, input write, input addr, input wdata, output done, output rdata);
endinterface

// file: hdl/fesp_pkg.sv
package fesp_pkg;
    localparam int unsigned CLK_HZ          = 20000000;
    localparam int unsigned ADDR_W          = 19;
    localparam int unsigned DATA_W          = 8;
    localparam int unsigned NUM_SECTORS     = 11;
    localparam int unsigned SECT_W          = 4;
    // bus cycle phase lengths in core clocks, minus one (each phase lasts value + 1 clocks)
    localparam logic [3:0]  WR_SETUP_CYC    = 4'h1;
    localparam logic [3:0]  WR_PULSE_CYC    = 4'h2;
    localparam logic [3:0]  WR_HOLD_CYC     = 4'h2;
    localparam logic [3:0]  RD_ACCESS_CYC   = 4'h3;
    localparam int unsigned VID_SETTLE_US   = 1;
    localparam int unsigned PROT_WAIT_US    = 150;
    localparam int unsigned UNPROT_WAIT_MS  = 15;
    localparam int unsigned VID_SETTLE_CYC  = (VID_SETTLE_US * (CLK_HZ / 1000000));
    localparam int unsigned PROT_WAIT_CYC   = (PROT_WAIT_US * (CLK_HZ / 1000000));
    localparam int unsigned UNPROT_WAIT_CYC = (UNPROT_WAIT_MS * (CLK_HZ / 1000));
    localparam int unsigned WAIT_W          = 24;
    localparam logic [DATA_W-1:0] CMD_UNLOCK1   = 8'haa;
    localparam logic [DATA_W-1:0] CMD_UNLOCK2   = 8'h55;
    localparam logic [DATA_W-1:0] CMD_ERASE_SET = 8'h80;
    localparam logic [DATA_W-1:0] CMD_CHIP_ERS  = 8'h10;
    localparam logic [DATA_W-1:0] CMD_PROT_PLS  = 8'h60;
    localparam logic [DATA_W-1:0] CMD_PROT_VFY  = 8'h40;
    localparam logic [DATA_W-1:0] CMD_RESET     = 8'hf0;
    localparam logic [DATA_W-1:0] ERASED_DATA   = 8'hff;
    localparam logic [DATA_W-1:0] PROT_OK_DATA  = 8'h01;
    localparam logic [DATA_W-1:0] UNPROT_OK_DATA = 8'h00;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR1  = 19'h00555;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR2  = 19'h002aa;
    localparam int unsigned PROT_SEL_BIT  = 6;
    localparam int unsigned PROT_MODE_BIT = 1;
    localparam int unsigned PROT_LOW_BIT  = 0;
    localparam logic [10:0] PROT_MAX_PULSES   = 11'h019;
    localparam logic [10:0] UNPROT_MAX_PULSES = 11'h3e8;
    localparam logic [2:0]  ERASE_SEQ_LEN     = 3'h6;

    typedef enum logic [1:0] {
        FESP_OP_ERASE   = 2'h0,
        FESP_OP_PROTECT = 2'h1,
        FESP_OP_UNPROT  = 2'h2
    } fesp_op_type;
endpackage

// file: hdl/fesp_sequencer.sv
`timescale 1ns/1ps
module fesp_sequencer #(
    parameter int unsigned PROT_WAIT_CYC   = fesp_pkg::PROT_WAIT_CYC,
    parameter int unsigned UNPROT_WAIT_CYC = fesp_pkg::UNPROT_WAIT_CYC
) (
    input  wire logic                              core_clk,
    input  wire logic                              rstn,
    input  wire logic                              req_valid,
    input  wire fesp_pkg::fesp_op_type             req_op,
    input  wire logic [fesp_pkg::ADDR_W-1:0]       sector_base [fesp_pkg::NUM_SECTORS],
    output logic                                   req_ready,
    output logic                                   op_done,
    output logic                                   op_failed,
    output logic      [fesp_pkg::ADDR_W-1:0]       flash_addr,
    input  wire logic [fesp_pkg::DATA_W-1:0]       flash_dq_in,
    output logic      [fesp_pkg::DATA_W-1:0]       flash_dq_out,
    output logic                                   flash_dq_oe_n,
    output logic                                   flash_ce_n,
    output logic                                   flash_we_n,
    output logic                                   flash_oe_n,
    output logic                                   flash_reset_vid
);
    typedef enum logic [3:0] {
        SQ_IDLE, SQ_ERS_WR, SQ_ERS_POLL, SQ_VID_ON, SQ_PROT_PLS, SQ_PROT_WAIT, SQ_PROT_VFY_WR,
        SQ_PROT_VFY_RD, SQ_UNP_PLS, SQ_UNP_WAIT, SQ_UNP_VFY_WR, SQ_UNP_VFY_RD, SQ_VID_OFF, SQ_RESET_WR,
        SQ_FINISH
    } fesp_sq_state_type;

    typedef struct packed {
        fesp_sq_state_type              st;
        logic                           unprot_job;
        logic                           busy;
        logic                           issued;
        logic [2:0]                     step;
        logic [fesp_pkg::SECT_W-1:0]    sect;
        logic [10:0]                    pulse_attempt_count;
        logic [fesp_pkg::WAIT_W-1:0]    wait_cnt;
        logic                           failed;
        logic                           done;
        logic                           vid;
    } fesp_sq_reg_type;
    fesp_sq_reg_type s_q, s_d;

    fesp_cyc_if cyc ();

    fesp_bus_cycle u_cycle (
        .core_clk (core_clk),
        .rstn     (rstn),
        .cyc      (cyc),
        .dq_in    (flash_dq_in),
        .addr_o   (flash_addr),
        .dq_out   (flash_dq_out),
        .dq_oe_n  (flash_dq_oe_n),
        .ce_n     (flash_ce_n),
        .we_n     (flash_we_n),
        .oe_n     (flash_oe_n)
    );

    // sector base with protect mode bits forced
    function automatic logic [fesp_pkg::ADDR_W-1:0] prot_addr(input logic [fesp_pkg::ADDR_W-1:0] base,
                                                               input logic unprot);
        logic [fesp_pkg::ADDR_W-1:0] a;
        a = base;
        a[fesp_pkg::PROT_SEL_BIT]  = unprot;
        a[fesp_pkg::PROT_MODE_BIT] = 1'b1;
        a[fesp_pkg::PROT_LOW_BIT]  = 1'b0;
        return a;
    endfunction

    function automatic logic [fesp_pkg::ADDR_W-1:0] erase_addr(input logic [2:0] step);
        return (step == 3'h1 || step == 3'h4) ? fesp_pkg::UNLOCK_ADDR2 : fesp_pkg::UNLOCK_ADDR1;
    endfunction

    function automatic logic [fesp_pkg::DATA_W-1:0] erase_data(input logic [2:0] step);
        logic [fesp_pkg::DATA_W-1:0] d;
        unique case (step)
            3'h1, 3'h4: d = fesp_pkg::CMD_UNLOCK2;
            3'h2:       d = fesp_pkg::CMD_ERASE_SET;
            3'h5:       d = fesp_pkg::CMD_CHIP_ERS;
            default:    d = fesp_pkg::CMD_UNLOCK1;
        endcase
        return d;
    endfunction

    logic [fesp_pkg::ADDR_W-1:0] cur_prot_addr;
    logic                        last_sect;
    assign cur_prot_addr = prot_addr(sector_base[s_q.sect], s_q.unprot_job);
    assign last_sect     = (s_q.sect == fesp_pkg::SECT_W'(fesp_pkg::NUM_SECTORS - 1));

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        cyc.start = 1'b0;
        cyc.write = 1'b1;
        cyc.addr  = cur_prot_addr;
        cyc.wdata = fesp_pkg::CMD_PROT_PLS;
        if (s_q.wait_cnt != '0) begin
            s_d.wait_cnt = s_q.wait_cnt - 1'b1;
        end
        unique case (s_q.st)
            SQ_IDLE: begin
                if (req_valid) begin
                    s_d.busy   = 1'b1;
                    s_d.failed = 1'b0;
                    s_d.step   = '0;
                    s_d.sect   = '0;
                    s_d.issued = 1'b0;
                    s_d.pulse_attempt_count = 11'h001;
                    s_d.unprot_job = (req_op == fesp_pkg::FESP_OP_UNPROT);
                    if (req_op == fesp_pkg::FESP_OP_ERASE) begin
                        s_d.st = SQ_ERS_WR;
                    end else begin
                        s_d.vid      = 1'b1;
                        s_d.wait_cnt = fesp_pkg::WAIT_W'(fesp_pkg::VID_SETTLE_CYC);
                        s_d.st       = SQ_VID_ON;
                    end
                end
            end
            SQ_ERS_WR: begin
                cyc.addr  = erase_addr(s_q.step);
                cyc.wdata = erase_data(s_q.step);
                cyc.start = !s_q.issued;
                s_d.issued = 1'b1;
                if (cyc.done) begin
                    s_d.issued = 1'b0;
                    s_d.step   = s_q.step + 3'h1;
                    if (s_q.step == fesp_pkg::ERASE_SEQ_LEN - 3'h1) begin
                        s_d.st = SQ_ERS_POLL;
                    end
                end
            end
            SQ_ERS_POLL: begin
                // every address is inside a chip erase
                cyc.addr  = fesp_pkg::UNLOCK_ADDR1;
                cyc.write = 1'b0;
                cyc.start = !s_q.issued;
                s_d.issued = 1'b1;
                if (cyc.done) begin
                    s_d.issued = 1'b0;
                    if (cyc.rdata == fesp_pkg::ERASED_DATA) begin
                        s_d.st = SQ_FINISH;
                    end
                end
            end
            SQ_VID_ON: if (s_q.wait_cnt == '0) begin
                // unprotect first protects every sector
                s_d.st = SQ_PROT_PLS;
            end
            SQ_PROT_PLS, SQ_UNP_PLS: begin
                cyc.addr  = prot_addr(sector_base[s_q.sect], s_q.st == SQ_UNP_PLS);
                cyc.start = !s_q.issued;
                s_d.issued = 1'b1;
                if (cyc.done) begin
                    s_d.issued = 1'b0;
                    if (s_q.st == SQ_PROT_PLS) begin
                        s_d.wait_cnt = fesp_pkg::WAIT_W'(PROT_WAIT_CYC);
                        s_d.st       = SQ_PROT_WAIT;
                    end else begin
                        s_d.wait_cnt = fesp_pkg::WAIT_W'(UNPROT_WAIT_CYC);
                        s_d.st       = SQ_UNP_WAIT;
                    end
                end
            end
            SQ_PROT_WAIT: if (s_q.wait_cnt == '0) s_d.st = SQ_PROT_VFY_WR;
            SQ_UNP_WAIT:  if (s_q.wait_cnt == '0) s_d.st = SQ_UNP_VFY_WR;
            SQ_PROT_VFY_WR, SQ_UNP_VFY_WR: begin
                cyc.addr  = prot_addr(sector_base[s_q.sect], s_q.st == SQ_UNP_VFY_WR);
                cyc.wdata = fesp_pkg::CMD_PROT_VFY;
                cyc.start = !s_q.issued;
                s_d.issued = 1'b1;
                if (cyc.done) begin
                    s_d.issued = 1'b0;
                    s_d.st = (s_q.st == SQ_PROT_VFY_WR) ? SQ_PROT_VFY_RD : SQ_UNP_VFY_RD;
                end
            end
            SQ_PROT_VFY_RD: begin
                cyc.addr  = prot_addr(sector_base[s_q.sect], 1'b0);
                cyc.write = 1'b0;
                cyc.start = !s_q.issued;
                s_d.issued = 1'b1;
                if (cyc.done) begin
                    s_d.issued = 1'b0;
                    if (cyc.rdata == fesp_pkg::PROT_OK_DATA) begin
                        s_d.pulse_attempt_count = 11'h001;
                        if (!last_sect) begin
                            s_d.sect = s_q.sect + 1'b1;
                            s_d.st   = SQ_PROT_PLS;
                        end else begin
                            s_d.sect = '0;
                            s_d.st   = s_q.unprot_job ? SQ_UNP_PLS : SQ_VID_OFF;
                        end
                    end else if (s_q.pulse_attempt_count == fesp_pkg::PROT_MAX_PULSES) begin
                        s_d.failed = 1'b1;
                        s_d.st     = SQ_VID_OFF;
                    end else begin
                        s_d.pulse_attempt_count = s_q.pulse_attempt_count + 11'h001;
                        s_d.st = SQ_PROT_PLS;
                    end
                end
            end
            SQ_UNP_VFY_RD: begin
                cyc.addr  = prot_addr(sector_base[s_q.sect], 1'b1);
                cyc.write = 1'b0;
                cyc.start = !s_q.issued;
                s_d.issued = 1'b1;
                if (cyc.done) begin
                    s_d.issued = 1'b0;
                    if (cyc.rdata == fesp_pkg::UNPROT_OK_DATA) begin
                        s_d.pulse_attempt_count = 11'h001;
                        if (!last_sect) begin
                            s_d.sect = s_q.sect + 1'b1;
                            s_d.st   = SQ_UNP_PLS;
                        end else begin
                            s_d.st = SQ_VID_OFF;
                        end
                    end else if (s_q.pulse_attempt_count == fesp_pkg::UNPROT_MAX_PULSES) begin
                        s_d.failed = 1'b1;
                        s_d.st     = SQ_VID_OFF;
                    end else begin
                        s_d.pulse_attempt_count = s_q.pulse_attempt_count + 11'h001;
                        s_d.st = SQ_UNP_PLS;
                    end
                end
            end
            SQ_VID_OFF: begin
                // vid drops before the reset command, even on failure
                s_d.vid      = 1'b0;
                s_d.wait_cnt = fesp_pkg::WAIT_W'(fesp_pkg::VID_SETTLE_CYC);
                s_d.st       = SQ_RESET_WR;
            end
            SQ_RESET_WR: if (s_q.wait_cnt == '0) begin
                cyc.addr  = fesp_pkg::UNLOCK_ADDR1;
                cyc.wdata = fesp_pkg::CMD_RESET;
                cyc.start = !s_q.issued;
                s_d.issued = 1'b1;
                if (cyc.done) begin
                    s_d.issued = 1'b0;
                    s_d.st = SQ_FINISH;
                end
            end
            SQ_FINISH: begin
                s_d.done = 1'b1;
                s_d.busy = 1'b0;
                s_d.st   = SQ_IDLE;
            end
            default: s_d.st = SQ_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{st: SQ_IDLE, unprot_job: 1'b0, busy: 1'b0, issued: 1'b0, step: '0, sect: '0,
                     pulse_attempt_count: 11'h001, wait_cnt: '0, failed: 1'b0, done: 1'b0, vid: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign req_ready       = !s_q.busy;
    assign op_done         = s_q.done;
    assign op_failed       = s_q.failed;
    assign flash_reset_vid = s_q.vid;
endmodule
